/* File: rtl/sesum_top.sv */
// Status event summary: four register sets, two queues, status byte, AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "sesum_map.svh"
module sesum_top
  import sesum_pkg::*;
#(
  parameter int W = 16,
  parameter int OQ_DEPTH = 16,
  parameter int EQ_DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] std_cond_in,
  input wire logic [W-1:0] std_evt_in,
  input wire logic [W-1:0] opr_cond_in,
  input wire logic [W-1:0] opr_evt_in,
  input wire logic [W-1:0] mea_cond_in,
  input wire logic [W-1:0] mea_evt_in,
  input wire logic [W-1:0] que_cond_in,
  input wire logic [W-1:0] que_evt_in,
  input wire logic out_msg_push,
  input wire logic out_msg_pop,
  input wire logic err_msg_push,
  input wire logic err_msg_pop,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic service_request,
  output logic [7:0] status_byte
);
  ////////////////////////////////////////////////////////////////
  // Write channel state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  sesum_req_t wreq_reg, wreq_next;
  logic wr_fire;
  // Read channel state
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic rd_fire;
  // Status byte state
  logic [7:0] sre_reg, sre_next;
  logic rqs_reg, rqs_next;
  logic [7:0] sum_prev_reg;
  logic [7:0] stb_out_reg;
  logic srq_out_reg;
  // Command strobes decoded from the command register write
  logic cmd_cls, cmd_spreset, cmd_qclr, cmd_sclr;
  logic wr_std_en, wr_opr_en, wr_mea_en, wr_que_en;
  logic rd_std_evt, rd_opr_evt, rd_mea_evt, rd_que_evt, rd_spoll;
  sesum_set_view_t std_v, opr_v, mea_v, que_v;
  logic std_sum, opr_sum, mea_sum, que_sum;
  logic [$clog2(OQ_DEPTH+1)-1:0] oq_count;
  logic [$clog2(EQ_DEPTH+1)-1:0] eq_count;
  logic oq_ne, eq_ne;
  logic [7:0] sum_bits, enabled_sum;
  logic master_summary_flag;
  logic [7:0] stb_val;
  logic [15:0] wlow;

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order, then one response
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    wreq_next = wreq_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      wreq_next.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wreq_next.data = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      case (wreq_reg.addr)
        `SESUM_OFF_STD_EN, `SESUM_OFF_OPR_EN, `SESUM_OFF_MEA_EN, `SESUM_OFF_QUE_EN,
        `SESUM_OFF_SRE, `SESUM_OFF_CMD: bresp_next = `SESUM_RESP_OKAY;
        default: bresp_next = `SESUM_RESP_SLVERR; // Read-only or unmapped
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wreq_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SESUM_RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      wreq_reg <= wreq_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Write decode; byte strobes are ignored because every register is written whole
  assign wlow = wreq_reg.data[15:0];
  assign wr_std_en = wr_fire && wreq_reg.addr == `SESUM_OFF_STD_EN;
  assign wr_opr_en = wr_fire && wreq_reg.addr == `SESUM_OFF_OPR_EN;
  assign wr_mea_en = wr_fire && wreq_reg.addr == `SESUM_OFF_MEA_EN;
  assign wr_que_en = wr_fire && wreq_reg.addr == `SESUM_OFF_QUE_EN;
  // System preset and device reset codes are accepted and deliberately do nothing
  assign cmd_cls = wr_fire && wreq_reg.addr == `SESUM_OFF_CMD
                   && wreq_reg.data[`SESUM_CMD_CLS];
  assign cmd_spreset = wr_fire && wreq_reg.addr == `SESUM_OFF_CMD
                       && wreq_reg.data[`SESUM_CMD_STAT_PRESET];
  assign cmd_qclr = wr_fire && wreq_reg.addr == `SESUM_OFF_CMD
                    && wreq_reg.data[`SESUM_CMD_QUEUE_CLEAR];
  assign cmd_sclr = wr_fire && wreq_reg.addr == `SESUM_OFF_CMD
                    && wreq_reg.data[`SESUM_CMD_SYS_CLEAR];

  ////////////////////////////////////////////////////////////////
  // Register sets; the standard set never sees status preset
  sesum_set #(.W(W)) u_std (.aclk(aclk), .aresetn(aresetn), .cond_in(std_cond_in),
    .evt_in(std_evt_in), .evt_clr(cmd_cls), .evt_read_clr(rd_std_evt), .en_wr(wr_std_en),
    .en_wdata(wlow[W-1:0]), .en_preset(1'b0), .view(std_v), .summary(std_sum));
  sesum_set #(.W(W)) u_opr (.aclk(aclk), .aresetn(aresetn), .cond_in(opr_cond_in),
    .evt_in(opr_evt_in), .evt_clr(cmd_cls), .evt_read_clr(rd_opr_evt), .en_wr(wr_opr_en),
    .en_wdata(wlow[W-1:0]), .en_preset(cmd_spreset), .view(opr_v), .summary(opr_sum));
  sesum_set #(.W(W)) u_mea (.aclk(aclk), .aresetn(aresetn), .cond_in(mea_cond_in),
    .evt_in(mea_evt_in), .evt_clr(cmd_cls), .evt_read_clr(rd_mea_evt), .en_wr(wr_mea_en),
    .en_wdata(wlow[W-1:0]), .en_preset(cmd_spreset), .view(mea_v), .summary(mea_sum));
  sesum_set #(.W(W)) u_que (.aclk(aclk), .aresetn(aresetn), .cond_in(que_cond_in),
    .evt_in(que_evt_in), .evt_clr(cmd_cls), .evt_read_clr(rd_que_evt), .en_wr(wr_que_en),
    .en_wdata(wlow[W-1:0]), .en_preset(cmd_spreset), .view(que_v), .summary(que_sum));

  // Queues: status preset is not wired to the error queue
  sesum_qcnt #(.DEPTH(OQ_DEPTH)) u_oq (.aclk(aclk), .aresetn(aresetn), .push(out_msg_push),
    .pop(out_msg_pop), .clr(1'b0), .count(oq_count), .nonempty(oq_ne));
  sesum_qcnt #(.DEPTH(EQ_DEPTH)) u_eq (.aclk(aclk), .aresetn(aresetn), .push(err_msg_push),
    .pop(err_msg_pop), .clr(cmd_cls || cmd_qclr || cmd_sclr),
    .count(eq_count), .nonempty(eq_ne));

  ////////////////////////////////////////////////////////////////
  // Status byte summaries follow their sources directly
  always_comb begin
    sum_bits = `SESUM_ZERO8;
    sum_bits[`SESUM_STB_MEAS] = mea_sum;
    sum_bits[`SESUM_STB_EAV] = eq_ne;
    sum_bits[`SESUM_STB_QUES] = que_sum;
    sum_bits[`SESUM_STB_MAV] = oq_ne;
    sum_bits[`SESUM_STB_ESB] = std_sum;
    sum_bits[`SESUM_STB_OSB] = opr_sum;
  end
  assign enabled_sum = sum_bits & sre_reg & `SESUM_STB_SUM_MASK;
  assign master_summary_flag = |enabled_sum;
  always_comb begin
    stb_val = sum_bits;
    stb_val[`SESUM_STB_RQS] = master_summary_flag;
  end

  // Request service: set on a newly enabled rising summary, cleared by poll; set wins
  always_comb begin
    sre_next = sre_reg;
    if (wr_fire && wreq_reg.addr == `SESUM_OFF_SRE) begin
      sre_next = wreq_reg.data[7:0] & `SESUM_STB_SUM_MASK;
    end
    rqs_next = rqs_reg;
    if (rd_spoll) begin
      rqs_next = 1'b0;
    end
    if (|(enabled_sum & ~sum_prev_reg)) begin
      rqs_next = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sre_reg <= `SESUM_ZERO8;
      rqs_reg <= 1'b0;
      sum_prev_reg <= `SESUM_ZERO8;
      stb_out_reg <= `SESUM_ZERO8;
      srq_out_reg <= 1'b0;
    end else begin
      sre_reg <= sre_next;
      rqs_reg <= rqs_next;
      sum_prev_reg <= enabled_sum;
      stb_out_reg <= stb_val;
      srq_out_reg <= rqs_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one outstanding; event and poll reads have a clearing side effect
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign rd_std_evt = rd_fire && s_axi_araddr == `SESUM_OFF_STD_EVT;
  assign rd_opr_evt = rd_fire && s_axi_araddr == `SESUM_OFF_OPR_EVT;
  assign rd_mea_evt = rd_fire && s_axi_araddr == `SESUM_OFF_MEA_EVT;
  assign rd_que_evt = rd_fire && s_axi_araddr == `SESUM_OFF_QUE_EVT;
  assign rd_spoll = rd_fire && s_axi_araddr == `SESUM_OFF_SPOLL;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = `SESUM_RESP_OKAY;
      rdata_next = '0; // Upper bits and bit 15 read zero
      case (s_axi_araddr)
        `SESUM_OFF_STD_COND: rdata_next[15:0] = std_v.cond;
        `SESUM_OFF_STD_EVT: rdata_next[15:0] = std_v.evt;
        `SESUM_OFF_STD_EN: rdata_next[15:0] = std_v.en;
        `SESUM_OFF_OPR_COND: rdata_next[15:0] = opr_v.cond;
        `SESUM_OFF_OPR_EVT: rdata_next[15:0] = opr_v.evt;
        `SESUM_OFF_OPR_EN: rdata_next[15:0] = opr_v.en;
        `SESUM_OFF_MEA_COND: rdata_next[15:0] = mea_v.cond;
        `SESUM_OFF_MEA_EVT: rdata_next[15:0] = mea_v.evt;
        `SESUM_OFF_MEA_EN: rdata_next[15:0] = mea_v.en;
        `SESUM_OFF_QUE_COND: rdata_next[15:0] = que_v.cond;
        `SESUM_OFF_QUE_EVT: rdata_next[15:0] = que_v.evt;
        `SESUM_OFF_QUE_EN: rdata_next[15:0] = que_v.en;
        `SESUM_OFF_STB: rdata_next[7:0] = stb_val; // Bit 6 is master summary
        `SESUM_OFF_SPOLL: begin
          rdata_next[7:0] = stb_val;
          rdata_next[`SESUM_STB_RQS] = rqs_reg; // Bit 6 is request service
        end
        `SESUM_OFF_SRE: rdata_next[7:0] = sre_reg;
        `SESUM_OFF_CMD: rdata_next = '0;
        `SESUM_OFF_QSTAT: rdata_next[15:0] = {8'(oq_count), 8'(eq_count)};
        default: rresp_next = `SESUM_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `SESUM_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign status_byte = stb_out_reg;
  assign service_request = srq_out_reg;
endmodule
`default_nettype wire

/* File: rtl/sesum_map.svh */
// Register offsets, bit positions and reset values of the status event summary block
`ifndef SESUM_MAP_SVH
`define SESUM_MAP_SVH
`define SESUM_OFF_STD_COND 8'h00
`define SESUM_OFF_STD_EVT 8'h04
`define SESUM_OFF_STD_EN 8'h08
`define SESUM_OFF_OPR_COND 8'h0c
`define SESUM_OFF_OPR_EVT 8'h10
`define SESUM_OFF_OPR_EN 8'h14
`define SESUM_OFF_MEA_COND 8'h18
`define SESUM_OFF_MEA_EVT 8'h1c
`define SESUM_OFF_MEA_EN 8'h20
`define SESUM_OFF_QUE_COND 8'h24
`define SESUM_OFF_QUE_EVT 8'h28
`define SESUM_OFF_QUE_EN 8'h2c
`define SESUM_OFF_STB 8'h30
`define SESUM_OFF_SPOLL 8'h34
`define SESUM_OFF_SRE 8'h38
`define SESUM_OFF_CMD 8'h3c
`define SESUM_OFF_QSTAT 8'h40
`define SESUM_CMD_CLS 0
`define SESUM_CMD_STAT_PRESET 1
`define SESUM_CMD_QUEUE_CLEAR 2
`define SESUM_CMD_SYS_CLEAR 3
`define SESUM_CMD_SYS_PRESET 4
`define SESUM_CMD_DEV_RESET 5
`define SESUM_STB_MEAS 0
`define SESUM_STB_EAV 2
`define SESUM_STB_QUES 3
`define SESUM_STB_MAV 4
`define SESUM_STB_ESB 5
`define SESUM_STB_RQS 6
`define SESUM_STB_OSB 7
`define SESUM_STB_SUM_MASK 8'hbf
`define SESUM_REG_MASK 16'h7fff
`define SESUM_ZERO16 16'h0000
`define SESUM_ZERO8 8'h00
`define SESUM_RESP_OKAY 2'b00
`define SESUM_RESP_SLVERR 2'b10
`endif

/* File: rtl/sesum_pkg.sv */
// Types shared by the status event summary block
`default_nettype none
package sesum_pkg;
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] evt;
    logic [15:0] en;
  } sesum_set_view_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } sesum_req_t;
endpackage
`default_nettype wire

/* File: rtl/sesum_set.sv */
// One status register set: condition tracking, sticky events, enable and summary
`default_nettype none
`include "sesum_map.svh"
module sesum_set
  import sesum_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] cond_in,
  input wire logic [W-1:0] evt_in,
  input wire logic evt_clr,
  input wire logic evt_read_clr,
  input wire logic en_wr,
  input wire logic [W-1:0] en_wdata,
  input wire logic en_preset,
  output sesum_set_view_t view,
  output logic summary
);
  logic [W-1:0] evt_reg, evt_next, en_reg, en_next;
  logic [W-1:0] mask;
  assign mask = W'(`SESUM_REG_MASK);
  ////////////////////////////////////////////////////////////////
  // Events stick; a new event in the clearing cycle survives the clear
  always_comb begin
    evt_next = evt_reg;
    if (evt_clr || evt_read_clr) begin
      evt_next = W'(`SESUM_ZERO16);
    end
    evt_next = (evt_next | evt_in) & mask;
    en_next = en_reg;
    if (en_preset) begin
      en_next = W'(`SESUM_ZERO16);
    end
    if (en_wr) begin
      en_next = en_wdata & mask;
    end
  end
  // Power-on clears both stored registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_reg <= W'(`SESUM_ZERO16);
      en_reg <= W'(`SESUM_ZERO16);
    end else begin
      evt_reg <= evt_next;
      en_reg <= en_next;
    end
  end
  // Condition is a live view with no latch
  assign view.cond = 16'(cond_in & mask);
  assign view.evt = 16'(evt_reg);
  assign view.en = 16'(en_reg);
  assign summary = |(evt_reg & en_reg);
endmodule
`default_nettype wire

/* File: rtl/sesum_qcnt.sv */
// Occupancy tracker for one message queue; only its fill level matters here
`default_nettype none
module sesum_qcnt #(
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic pop,
  input wire logic clr,
  output logic [CW-1:0] count,
  output logic nonempty
);
  logic [CW-1:0] cnt_reg, cnt_next;
  // Push is dropped when full, pop when empty: a lost message beats a wrapped count
  always_comb begin
    cnt_next = cnt_reg;
    if (clr) begin
      cnt_next = '0;
    end else if (push && !pop && cnt_reg != CW'(DEPTH)) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign count = cnt_reg;
  assign nonempty = (cnt_reg != '0);
endmodule
`default_nettype wire

/* File: sim/sesum_top_sva.sv */
// Concurrent checks on the status event summary block ports
`default_nettype none
`include "sesum_map.svh"
module sesum_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic out_msg_push,
  input wire logic err_msg_push,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic service_request,
  input wire logic [7:0] status_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // A serial poll is a read of the poll byte taken by the slave
  sequence s_poll;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `SESUM_OFF_SPOLL;
  endsequence
  sequence s_rqs_rise;
    $rose(service_request);
  endsequence
  property p_unused_bit;
    status_byte[1] == 1'b0;
  endproperty
  // Master summary needs at least one summary bit behind it
  property p_mss_cause;
    status_byte[6] |-> (status_byte & `SESUM_STB_SUM_MASK) != 8'h00;
  endproperty
  property p_eav;
    err_msg_push |-> ##[1:3] status_byte[`SESUM_STB_EAV];
  endproperty
  property p_mav;
    out_msg_push |-> ##[1:3] status_byte[`SESUM_STB_MAV];
  endproperty
  // Reset must be seen even while reset is low, so no disable here
  property p_reset;
    disable iff (1'b0) !aresetn |=> status_byte == 8'h00 && !service_request && !s_axi_bvalid;
  endproperty
  property p_rqs_mss;
    s_rqs_rise |-> ##[0:2] status_byte[6];
  endproperty
  property p_poll_clr;
    s_poll |-> ##[1:2] !service_request;
  endproperty
  // Request service is a level that only a poll takes down
  property p_rqs_hold;
    service_request
      && !(s_axi_arvalid && s_axi_arready && s_axi_araddr == `SESUM_OFF_SPOLL)
      |=> service_request;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("status byte bit 1 set");
  a_mss_cause: assert property (p_mss_cause) else $error("master summary alone");
  a_eav: assert property (p_eav) else $error("error summary missing");
  a_mav: assert property (p_mav) else $error("message summary missing");
  a_reset: assert property (p_reset) else $error("state after reset not clear");
  a_rqs_mss: assert property (p_rqs_mss) else $error("request without summary");
  a_poll_clr: assert property (p_poll_clr) else $error("poll left request set");
  a_rqs_hold: assert property (p_rqs_hold) else $error("request dropped early");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
endmodule
bind sesum_top sesum_top_sva sesum_top_sva_inst (.aclk, .aresetn, .out_msg_push,
  .err_msg_push, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .service_request, .status_byte);
`default_nettype wire

/* File: sim/sesum_host.sv */
// Remote controller model: AXI4-Lite master issuing register accesses
`default_nettype none
module sesum_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write; data lags the address by lag cycles, so the address comes first or with the data, never after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag,
                    output logic [1:0] r);
    fork
      begin
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        repeat (lag) @(posedge aclk);
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // Read; data and response are taken at the edge where rvalid is high
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_status_event_summary.sv */
// Self-checking testbench of the status event summary block
`default_nettype none
`include "sesum_map.svh"
module test_status_event_summary;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, out_msg_push, out_msg_pop, err_msg_push;
  logic [15:0] cond [4];
  logic [15:0] evt [4];
  logic [7:0] s_axi_awaddr, s_axi_araddr, status_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, service_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  localparam int SBP[4] = '{5, 7, 0, 3};
  // Bus ready lines held high: the bench always accepts answers at once
  sesum_top sesum_top_inst (.aclk, .aresetn, .std_cond_in(cond[0]), .std_evt_in(evt[0]),
    .opr_cond_in(cond[1]), .opr_evt_in(evt[1]), .mea_cond_in(cond[2]),
    .mea_evt_in(evt[2]), .que_cond_in(cond[3]), .que_evt_in(evt[3]), .out_msg_push,
    .out_msg_pop, .err_msg_push, .err_msg_pop(1'b0), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .service_request, .status_byte);
  sesum_host sesum_host_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    sesum_host_inst.rd(a, rdat, resp);
    chk($sformatf("register %h", a), rdat, e);
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    sesum_host_inst.wr(a, d, int'(a[3:2]), resp);
    chk("bresp", {30'h0, resp}, {30'h0, e});
  endtask
  // Status byte lags its sources, so give it three edges to settle
  task automatic sb(input logic [7:0] e);
    tick(3);
    chk("status_byte", {24'h0, status_byte}, {24'h0, e});
  endtask
  task automatic pulse_evt(input int i, input logic [15:0] v);
    evt[i] <= v;
    @(posedge aclk);
    evt[i] <= 16'h0000;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a <= 'h40; a += 4) rc(a[7:0], 32'h0);
    chk("status_byte", {24'h0, status_byte}, 32'h0);
  endtask
  task automatic t_sets();
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 8'(i * 12);
      cond[i] <= 16'hffff;
      tick(2);
      rc(b, 32'h7fff);
      cond[i] <= 16'h0005;
      tick(2);
      rc(b, 32'h0005);
      wc(b, 32'hffff, `SESUM_RESP_SLVERR);
      wc(b + 8'h08, 32'd26, `SESUM_RESP_OKAY);
      rc(b + 8'h08, 32'd26);
      pulse_evt(i, 16'h8004);
      sb(8'h00);
      pulse_evt(i, 16'h0008);
      sb(8'h01 << SBP[i]);
      rc(b + 8'h04, 32'h000c);
      sb(8'h00);
      rc(b + 8'h04, 32'h0);
    end
  endtask
  task automatic t_srq();
    wc(`SESUM_OFF_SRE, 32'hff, `SESUM_RESP_OKAY);
    rc(`SESUM_OFF_SRE, 32'hbf);
    err_msg_push <= 1'b1;
    @(posedge aclk);
    err_msg_push <= 1'b0;
    sb(8'h44);
    chk("service_request", {31'h0, service_request}, 32'h1);
    rc(`SESUM_OFF_SPOLL, 32'h44);
    tick(2);
    chk("service_request", {31'h0, service_request}, 32'h0);
    rc(`SESUM_OFF_STB, 32'h44);
    rc(`SESUM_OFF_SPOLL, 32'h04);
    wc(`SESUM_OFF_CMD, 32'h08, `SESUM_RESP_OKAY);
    sb(8'h00);
    wc(`SESUM_OFF_SRE, 32'h0, `SESUM_RESP_OKAY);
    rc(`SESUM_OFF_SRE, 32'h0);
  endtask
  task automatic t_cmds();
    for (int i = 0; i < 4; i++) wc(8'(i * 12 + 8), 32'h7fff, `SESUM_RESP_OKAY);
    err_msg_push <= 1'b1;
    out_msg_push <= 1'b1;
    @(posedge aclk);
    out_msg_push <= 1'b0;
    @(posedge aclk);
    err_msg_push <= 1'b0;
    evt <= '{4{16'h0001}};
    @(posedge aclk);
    evt <= '{4{16'h0000}};
    sb(8'hbd);
    wc(`SESUM_OFF_CMD, 32'h10, `SESUM_RESP_OKAY);
    wc(`SESUM_OFF_CMD, 32'h20, `SESUM_RESP_OKAY);
    sb(8'hbd);
    rc(`SESUM_OFF_QSTAT, 32'h0102);
    wc(`SESUM_OFF_CMD, 32'h02, `SESUM_RESP_OKAY);
    for (int i = 1; i < 4; i++) rc(8'(i * 12 + 8), 32'h0);
    rc(`SESUM_OFF_STD_EN, 32'h7fff);
    rc(`SESUM_OFF_QSTAT, 32'h0102);
    sb(8'h34);
    wc(`SESUM_OFF_CMD, 32'h01, `SESUM_RESP_OKAY);
    sb(8'h10);
    rc(`SESUM_OFF_QSTAT, 32'h0100);
    rc(`SESUM_OFF_STD_EN, 32'h7fff);
    for (int i = 0; i < 4; i++) rc(8'(i * 12 + 4), 32'h0);
    err_msg_push <= 1'b1;
    @(posedge aclk);
    err_msg_push <= 1'b0;
    wc(`SESUM_OFF_CMD, 32'h04, `SESUM_RESP_OKAY);
    rc(`SESUM_OFF_QSTAT, 32'h0100);
    out_msg_pop <= 1'b1;
    @(posedge aclk);
    out_msg_pop <= 1'b0;
    sb(8'h00);
    wc(`SESUM_OFF_STD_EN, 32'h0, `SESUM_RESP_OKAY);
    rc(`SESUM_OFF_STD_EN, 32'h0);
    rc(8'h44, 32'h0);
    chk("rresp", {30'h0, resp}, {30'h0, `SESUM_RESP_SLVERR});
    wc(`SESUM_OFF_STB, 32'h1, `SESUM_RESP_SLVERR);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    aresetn = 1'b0;
    cond = '{4{16'h0000}};
    evt = '{4{16'h0000}};
    out_msg_push = 1'b0;
    out_msg_pop = 1'b0;
    err_msg_push = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sets();
    t_srq();
    t_cmds();
    stop_test();
  end
endmodule
`default_nettype wire
